// >>> rtl/bue_logger.sv
// Uncorrectable data/address error logger of a PCIe to PCI bridge.
// Assumes event inputs are one-cycle pulses from core-clock logic; pins are async.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module bue_logger
    import bue_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata,
    input  wire bue_ev_s           ev,
    input  wire logic              parity_err_pin_n_i,
    output logic                   parity_err_pin_n_o,
    output logic                   parity_err_pin_oe,
    input  wire logic              system_err_pin_n,
    output logic                   err_msg_fatal,
    output logic                   err_msg_nonfatal,
    output logic                   irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and register block

    logic                 perr_n_s;
    logic                 serr_n_s;
    logic [DATA_W-1:0]    ctrl;
    logic [DATA_W-1:0]    sever;
    logic [NUM_FLAGS-1:0] status;
    logic [NUM_FLAGS-1:0] set_flags;
    bue_bus_s             bus;

    assign bus = '{wr: wr_en, rd: rd_en, addr: addr, wdata: wdata};

    bue_sync #(.RST_VAL(1'b1)) u_sync_perr (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (parity_err_pin_n_i),
        .q     (perr_n_s)
    );

    bue_sync #(.RST_VAL(1'b1)) u_sync_serr (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (system_err_pin_n),
        .q     (serr_n_s)
    );

    bue_regs u_regs (
        .clk       (clk),
        .rst_n     (rst_n),
        .bus       (bus),
        .set_flags (set_flags),
        .rdata     (rdata),
        .ctrl      (ctrl),
        .sever     (sever),
        .status    (status),
        .irq       (irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic perr_drive;   // Drive parity pin low this cycle
        logic own_d1;       // Own drive, one cycle late
        logic own_d2;       // Own drive, lined up with the synchronised pin
        logic perr_prev_n;  // Previous synced parity pin level
        logic serr_prev_n;  // Previous synced system error pin level
        logic msg_fatal;
        logic msg_nonfatal;
    } bue_log_s;

    bue_log_s st_q;
    bue_log_s st_d;

    logic [NUM_EV-1:0] evv;
    logic              perr_fall;
    logic              serr_fall;
    logic              perr_own;
    logic              any_fatal;
    logic              any_nonfatal;
    logic              peresp;

    assign peresp    = ctrl[CTL_PERESP];
    // Our own low reaches perr_n_s two cycles after we drive it
    assign perr_own  = st_q.own_d2;
    // Falling edges of synced pins; ignore our own drive
    assign perr_fall = st_q.perr_prev_n & ~perr_n_s & ~perr_own;
    assign serr_fall = st_q.serr_prev_n & ~serr_n_s;

    // Event vector in severity order
    always_comb begin
        evv               = '0;
        evv[EV_PCIE_DATA] = ev.pcie_data_err;
        evv[EV_NP_PERR]   = perr_fall & ev.fwd_active & ev.fwd_np_write;
        evv[EV_P_PERR]    = perr_fall & ev.fwd_active & ev.fwd_posted;
        evv[EV_SERR_PIN]  = serr_fall & ev.fwd_active;
        evv[EV_PCI_NPW]   = ev.pci_npw_err;
        evv[EV_PCI_PW]    = ev.pci_pw_err;
        evv[EV_DRC]       = ev.drc_data_err;
        evv[EV_ADDR]      = ev.addr_err;
    end

    // Severity split; system error pin and posted parity events carry no severity bit
    always_comb begin
        logic [NUM_EV-1:0] sev_ev;
        sev_ev = evv;
        sev_ev[EV_SERR_PIN] = 1'b0;
        sev_ev[EV_P_PERR]   = 1'b0;
        any_fatal    = |(sev_ev & sever[NUM_EV-1:0]);
        any_nonfatal = |(sev_ev & ~sever[NUM_EV-1:0]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag setting

    always_comb begin
        set_flags = '0;
        set_flags[ST_DPE]      = evv[EV_PCIE_DATA];
        set_flags[ST_FATAL]    = any_fatal;
        set_flags[ST_NONFATAL] = any_nonfatal;
        set_flags[ST_MSG]      = (any_fatal | any_nonfatal) & ctrl[CTL_MSGEN];
        set_flags[ST_SSE]      = (any_fatal | any_nonfatal) & ctrl[CTL_MSGEN]
                                 & ctrl[CTL_SERREN];
        set_flags[ST_MDP]      = peresp & (evv[EV_PCIE_DATA] | evv[EV_NP_PERR]
                                 | evv[EV_P_PERR] | evv[EV_PCI_PW]);
        set_flags[ST_UNC_DATA] = evv[EV_PCIE_DATA] | evv[EV_PCI_NPW] | evv[EV_PCI_PW];
        set_flags[ST_PERRAD]   = evv[EV_NP_PERR] | evv[EV_P_PERR] | evv[EV_DRC];
        set_flags[ST_RSE]      = evv[EV_SERR_PIN];
        set_flags[ST_SERRAD]   = evv[EV_SERR_PIN];
        set_flags[ST_SDPE]     = evv[EV_PCI_NPW] | evv[EV_PCI_PW] | evv[EV_ADDR];
        set_flags[ST_STA]      = evv[EV_ADDR];
        set_flags[ST_UADDR]    = evv[EV_ADDR];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive and message pulses

    always_comb begin
        st_d              = st_q;
        st_d.perr_drive   = peresp & (evv[EV_PCIE_DATA] | evv[EV_PCI_PW]);
        st_d.own_d1       = st_q.perr_drive;
        st_d.own_d2       = st_q.own_d1;
        st_d.perr_prev_n  = perr_n_s;
        st_d.serr_prev_n  = serr_n_s;
        st_d.msg_fatal    = any_fatal & ctrl[CTL_MSGEN];
        st_d.msg_nonfatal = any_nonfatal & ~any_fatal & ctrl[CTL_MSGEN];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{perr_drive: 1'b0, own_d1: 1'b0, own_d2: 1'b0,
                      perr_prev_n: 1'b1, serr_prev_n: 1'b1,
                      msg_fatal: 1'b0, msg_nonfatal: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign parity_err_pin_n_o = ~st_q.perr_drive;
    assign parity_err_pin_oe  = st_q.perr_drive;
    assign err_msg_fatal      = st_q.msg_fatal;
    assign err_msg_nonfatal   = st_q.msg_nonfatal;
endmodule // bue_logger

// >>> rtl/bue_pkg.sv
// Package for the bridge uncorrectable error logger.
// Assumes one core clock domain; register bus is a plain strobe port.
package bue_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;

    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SEVER  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 4'hc;

    // Control field positions
    localparam int unsigned CTL_PERESP = 0;
    localparam int unsigned CTL_SERREN = 1;
    localparam int unsigned CTL_MSGEN  = 2;

    // Severity bits: one per error event except EV_P_PERR and EV_SERR_PIN (ignored), 1 = fatal
    localparam int unsigned NUM_EV = 8;
    localparam int unsigned EV_PCIE_DATA  = 0;
    localparam int unsigned EV_NP_PERR    = 1;
    localparam int unsigned EV_P_PERR     = 2;
    localparam int unsigned EV_SERR_PIN   = 3;
    localparam int unsigned EV_PCI_NPW    = 4;
    localparam int unsigned EV_PCI_PW     = 5;
    localparam int unsigned EV_DRC        = 6;
    localparam int unsigned EV_ADDR       = 7;

    // Status flag positions
    localparam int unsigned NUM_FLAGS = 13;
    localparam int unsigned ST_DPE      = 0;   // detected_parity_err_flag
    localparam int unsigned ST_SSE      = 1;   // signalled_system_err_flag
    localparam int unsigned ST_FATAL    = 2;   // fatal_err_detected
    localparam int unsigned ST_NONFATAL = 3;   // nonfatal_err_detected
    localparam int unsigned ST_MDP      = 4;   // master_data_parity_flag
    localparam int unsigned ST_RSE      = 5;   // received system error, secondary
    localparam int unsigned ST_SDPE     = 6;   // secondary detected parity
    localparam int unsigned ST_STA      = 7;   // signalled_target_abort_flag
    localparam int unsigned ST_UNC_DATA = 8;   // sec_uncorr_data_err
    localparam int unsigned ST_PERRAD   = 9;   // sec_addr_data_parity_err
    localparam int unsigned ST_SERRAD   = 10;  // sec_system_err_seen
    localparam int unsigned ST_UADDR    = 11;  // sec_uncorr_addr_err
    localparam int unsigned ST_MSG      = 12;  // error message sent

    localparam logic [DATA_W-1:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] SEVER_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] MASK_RST  = 32'h0000_0000;

    // Error event inputs from the bridge datapath
    typedef struct packed {
        logic addr_err;       // Uncorrectable address error
        logic drc_data_err;   // Data error on delayed read completion
        logic pci_pw_err;     // Data error, PCI-originated posted write
        logic pci_npw_err;    // Data error, PCI-originated non-posted write
        logic fwd_active;     // Bridge forwards a PCIe transaction on PCI
        logic fwd_posted;     // That transaction is a posted write
        logic fwd_np_write;   // That transaction is a non-posted write
        logic pcie_data_err;  // Data error during completer response
    } bue_ev_s;

    // Bus request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bue_bus_s;

endpackage : bue_pkg

// >>> rtl/bue_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes reset value is the idle level given by parameter.
`timescale 1ns/10ps
module bue_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } bue_sync_s;

    bue_sync_s st_q;
    bue_sync_s st_d;

    // First stage feeds only the second
    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule // bue_sync

// >>> rtl/bue_regs.sv
// Control, severity, status and mask registers with write-one-to-clear status.
// Assumes single-cycle strobes from a master on the same clock.
`timescale 1ns/10ps
module bue_regs
    import bue_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire bue_bus_s             bus,
    input  wire logic [NUM_FLAGS-1:0] set_flags,
    output logic      [DATA_W-1:0]    rdata,
    output logic      [DATA_W-1:0]    ctrl,
    output logic      [DATA_W-1:0]    sever,
    output logic      [NUM_FLAGS-1:0] status,
    output logic                      irq
);
    typedef struct packed {
        logic [DATA_W-1:0]    ctrl;
        logic [DATA_W-1:0]    sever;
        logic [NUM_FLAGS-1:0] status;
        logic [NUM_FLAGS-1:0] mask;
        logic [DATA_W-1:0]    rdata;
    } bue_regs_s;

    bue_regs_s st_q;
    bue_regs_s st_d;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        return a == o;
    endfunction

    // Register update; hardware set wins over software clear
    always_comb begin
        st_d = st_q;
        if (bus.wr && hit(bus.addr, OFS_CTRL)) begin
            st_d.ctrl = bus.wdata;
        end
        if (bus.wr && hit(bus.addr, OFS_SEVER)) begin
            st_d.sever = bus.wdata;
        end
        if (bus.wr && hit(bus.addr, OFS_MASK)) begin
            st_d.mask = bus.wdata[NUM_FLAGS-1:0];
        end
        if (bus.wr && hit(bus.addr, OFS_STATUS)) begin
            st_d.status = st_q.status & ~bus.wdata[NUM_FLAGS-1:0];
        end
        st_d.status = st_d.status | set_flags;
        st_d.rdata  = '0;
        if (bus.rd) begin
            case (1'b1)
                hit(bus.addr, OFS_CTRL):   st_d.rdata = st_q.ctrl;
                hit(bus.addr, OFS_SEVER):  st_d.rdata = st_q.sever;
                hit(bus.addr, OFS_STATUS): st_d.rdata = {{(DATA_W-NUM_FLAGS){1'b0}}, st_q.status};
                hit(bus.addr, OFS_MASK):   st_d.rdata = {{(DATA_W-NUM_FLAGS){1'b0}}, st_q.mask};
                default:                   st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{ctrl: CTRL_RST, sever: SEVER_RST, status: '0,
                      mask: MASK_RST[NUM_FLAGS-1:0], rdata: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata  = st_q.rdata;
    assign ctrl   = st_q.ctrl;
    assign sever  = st_q.sever;
    assign status = st_q.status;
    assign irq    = |(st_q.status & st_q.mask);
endmodule // bue_regs

// >>> verif/bue_pci_agent.sv
// PCI bus agent model: pulls the parity and system error lines on request.
// Assumes pull-ups on both lines; the bridge may also pull the parity line.
`timescale 1ns/10ps
module bue_pci_agent (
    input  wire logic perr_req,
    input  wire logic serr_req,
    input  wire logic drv_n,
    input  wire logic drv_oe,
    output logic      perr_line_n,
    output logic      serr_line_n
);
    // Wired parity line: high unless a target or the bridge pulls it low
    assign perr_line_n = !(perr_req || (drv_oe && !drv_n));
    // System error line pulled by a target
    assign serr_line_n = !serr_req;
endmodule  // bue_pci_agent

// >>> verif/bue_logger_sva.sv
// Checker for the error logger ports.
// Assumes it is bound to bue_logger; control and severity are shadowed from bus writes.
`timescale 1ns/10ps
module bue_logger_sva
    import bue_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [DATA_W-1:0] rdata,
    input  wire bue_ev_s           ev,
    input  wire logic              parity_err_pin_n_o,
    input  wire logic              parity_err_pin_oe,
    input  wire logic              err_msg_fatal,
    input  wire logic              err_msg_nonfatal,
    input  wire logic              irq
);
    logic [2:0] ctl_q;
    logic [7:0] sev_q;
    // Shadow copies of control and severity
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_q <= 3'h0;
            sev_q <= 8'h00;
        end else if (wr_en && addr == OFS_CTRL) begin
            ctl_q <= wdata[2:0];
        end else if (wr_en && addr == OFS_SEVER) begin
            sev_q <= wdata[7:0];
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_drive; !parity_err_pin_n_o && parity_err_pin_oe; endsequence
    sequence s_msg; err_msg_fatal || err_msg_nonfatal; endsequence
    property p_pcie_pin; ev.pcie_data_err && ctl_q[CTL_PERESP] |=> s_drive; endproperty
    property p_pw_pin; ev.pci_pw_err && ctl_q[CTL_PERESP] |=> s_drive; endproperty
    property p_pin_cause; parity_err_pin_oe |-> $past(ev.pcie_data_err || ev.pci_pw_err); endproperty
    property p_pin_off; !ctl_q[CTL_PERESP] |=> !parity_err_pin_oe; endproperty
    property p_fatal_msg; ev.pcie_data_err && ctl_q[CTL_MSGEN] && sev_q[0] |=> err_msg_fatal; endproperty
    property p_addr_msg; ev.addr_err && ctl_q[CTL_MSGEN] |=> s_msg; endproperty
    property p_msg_gate; s_msg |-> $past(ctl_q[CTL_MSGEN]); endproperty
    property p_irq_sticky; irq && !wr_en |=> irq; endproperty
    property p_rdata_idle; !rd_en |=> rdata == 32'h0000_0000; endproperty
    a_pcie_pin: assert property (p_pcie_pin) else $error("parity pin not driven on completer data error");
    a_pw_pin: assert property (p_pw_pin) else $error("parity pin not driven on posted write error");
    a_pin_cause: assert property (p_pin_cause) else $error("parity pin driven without cause");
    a_pin_off: assert property (p_pin_off) else $error("parity pin driven with response off");
    a_fatal_msg: assert property (p_fatal_msg) else $error("fatal message missing");
    a_addr_msg: assert property (p_addr_msg) else $error("address error sent no message");
    a_msg_gate: assert property (p_msg_gate) else $error("message sent while disabled");
    a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt fell without a write");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
endmodule  // bue_logger_sva

bind bue_logger bue_logger_sva u_sva (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .ev(ev), .parity_err_pin_n_o(parity_err_pin_n_o),
    .parity_err_pin_oe(parity_err_pin_oe), .err_msg_fatal(err_msg_fatal),
    .err_msg_nonfatal(err_msg_nonfatal), .irq(irq));

// >>> verif/test_bridge_uncorrectable_error_logger.sv
// Testbench for the error logger: reset values, table of event cases, then sticky, interrupt and mid-run reset cases.
// Assumes bue_pci_agent stands for the PCI pins.
`timescale 1ns/10ps
module test_bridge_uncorrectable_error_logger
    import bue_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, perr_req = 1'b0, serr_req = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 32'h0, rdata, r;
    bue_ev_s ev = '0;
    logic pin_i, pin_o, oe, serr_n, fat, nf, irq;
    logic [2:0] seen;
    int n_fail = 0, cmp_count = 0;
    typedef struct packed {
        logic [7:0]  ev;   // Event pattern
        logic [1:0]  pin;  // Lines pulled: bit0 parity, bit1 system error
        logic [2:0]  ctl;  // Control word
        logic [7:0]  sev;  // Severity word
        logic [12:0] st;   // Expected status
        logic [2:0]  out;  // Expected {pin drive, fatal msg, non-fatal msg}
    } bue_row_s;
    localparam bue_row_s ROWS [10] = '{
        '{8'h01, 2'd0, 3'h7, 8'h01, 13'h1117, 3'b110}, '{8'h01, 2'd0, 3'h2, 8'h00, 13'h0109, 3'b000},
        '{8'h10, 2'd0, 3'h6, 8'h00, 13'h114a, 3'b001}, '{8'h20, 2'd0, 3'h1, 8'h20, 13'h0154, 3'b100},
        '{8'h40, 2'd0, 3'h4, 8'h00, 13'h1208, 3'b001}, '{8'h80, 2'd0, 3'h6, 8'h80, 13'h18c6, 3'b010},
        '{8'h0a, 2'd1, 3'h0, 8'h02, 13'h0204, 3'b000}, '{8'h0c, 2'd1, 3'h1, 8'h00, 13'h0210, 3'b000},
        '{8'h08, 2'd2, 3'h0, 8'h00, 13'h0420, 3'b000}, '{8'h2c, 2'd0, 3'h1, 8'h00, 13'h0158, 3'b100}};
    ////////////////////////////////////////
    bue_logger uut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .ev(ev), .parity_err_pin_n_i(pin_i), .parity_err_pin_n_o(pin_o),
        .parity_err_pin_oe(oe), .system_err_pin_n(serr_n), .err_msg_fatal(fat),
        .err_msg_nonfatal(nf), .irq(irq));
    bue_pci_agent u_agent (.perr_req(perr_req), .serr_req(serr_req), .drv_n(pin_o), .drv_oe(oe),
        .perr_line_n(pin_i), .serr_line_n(serr_n));
    // Clock generation
    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic bw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr_en <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic br(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        rd_en <= 1'b1; addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t outputs got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values of all four registers and idle outputs
        for (int k = 0; k < 4; k++) begin
            br(4'(4 * k), r);
            chk_reg(r, 32'h0);
        end
        chk_out({oe, fat, nf}, 3'b000);
        $display("reset test done");
        // Table of single events: pulse or pin, then status and outputs
        foreach (ROWS[i]) begin
            bw(OFS_CTRL, {29'h0, ROWS[i].ctl});
            bw(OFS_SEVER, {24'h0, ROWS[i].sev});
            bw(OFS_STATUS, 32'h1fff);
            @(posedge clk);
            ev <= ROWS[i].ev; perr_req <= ROWS[i].pin[0]; serr_req <= ROWS[i].pin[1];
            @(posedge clk);
            ev <= ROWS[i].ev & 8'h0e;
            #1 seen = {oe, fat, nf};
            repeat (6) begin
                @(posedge clk);
                perr_req <= 1'b0; serr_req <= 1'b0;
                #1 seen = seen | {oe, fat, nf};
            end
            ev <= '0;
            br(OFS_STATUS, r);
            chk_reg(r, {19'h0, ROWS[i].st});
            chk_out(seen, ROWS[i].out);
            $display("row %0d done", i);
        end
        // Back-to-back events accumulate; system error line outside forwarding is ignored
        bw(OFS_CTRL, 32'h0); bw(OFS_SEVER, 32'h0); bw(OFS_STATUS, 32'h1fff);
        @(posedge clk);
        ev <= 8'h40; serr_req <= 1'b1;
        @(posedge clk);
        ev <= 8'h80;
        @(posedge clk);
        ev <= '0; serr_req <= 1'b0;
        repeat (5) @(posedge clk);
        br(OFS_STATUS, r);
        chk_reg(r, 32'h0ac8);
        // Interrupt follows mask; partial one-to-clear keeps other flags
        bw(OFS_MASK, 32'h800);
        chk_reg({31'h0, irq}, 32'h1);
        bw(OFS_STATUS, 32'h200);
        br(OFS_STATUS, r);
        chk_reg(r, 32'h08c8);
        bw(OFS_STATUS, 32'h800);
        br(OFS_STATUS, r);
        chk_reg(r, 32'h00c8);
        chk_reg({31'h0, irq}, 32'h0);
        // Unmapped address reads zero
        bw(4'h2, 32'hffff_ffff);
        br(4'h2, r);
        chk_reg(r, 32'h0);
        $display("sticky and interrupt test done");
        // Reset in mid-run clears flags, mask and interrupt
        bw(OFS_MASK, 32'hc8);
        chk_reg({31'h0, irq}, 32'h1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        br(OFS_STATUS, r);
        chk_reg(r, 32'h0);
        br(OFS_MASK, r);
        chk_reg(r, 32'h0);
        chk_reg({31'h0, irq}, 32'h0);
        $display("mid-run reset test done");
        tally_and_finish;
    end
endmodule  // test_bridge_uncorrectable_error_logger
